// ### rtl/adcsq_pkg.sv
// constants, register map and types for the converter sequencer control block
package adcsq_pkg;
    localparam int            RES_BITS      = 10;
    // byte offsets on the register bus
    localparam logic [5:0]    OFF_CTRL_ONE  = 6'h00;
    localparam logic [5:0]    OFF_CTRL_TWO  = 6'h04;
    localparam logic [5:0]    OFF_RES_HIGH  = 6'h08;
    localparam logic [5:0]    OFF_RES_LOW   = 6'h0c;
    localparam logic [5:0]    OFF_IRQ_STAT  = 6'h10;
    localparam logic [5:0]    OFF_IRQ_MASK  = 6'h14;
    localparam logic [5:0]    OFF_STOP_CTRL = 6'h18;
    // control one fields
    localparam int            POS_START     = 7;
    localparam int            POS_MODE      = 5;
    localparam int            POS_AIN_DIS   = 4;
    localparam int            POS_CHAN      = 0;
    // control two fields
    localparam int            POS_LADDER    = 5;
    localparam int            POS_TIME      = 1;
    // result low fields
    localparam int            POS_EOC       = 5;
    localparam int            POS_BUSY      = 4;
    // reset values, fixed control two bits and mode codes
    localparam logic [7:0]    RST_CTRL_ONE  = 8'h1f;
    localparam logic [7:0]    RST_CTRL_TWO  = 8'h10;
    localparam logic [7:0]    CTRL_TWO_FIX  = 8'h10;
    localparam logic [1:0]    MODE_OFF      = 2'h0;
    localparam logic [1:0]    MODE_SOFT     = 2'h1;
    localparam logic [1:0]    MODE_REPEAT   = 2'h3;
    // conversion lengths in oscillator periods, and the width of the counter that counts them
    localparam int            TIME_CODE0    = 39;
    localparam int            TIME_CODE2    = 78;
    localparam int            TIME_CODE3    = 156;
    localparam int            TIME_CODE4    = 312;
    localparam int            TIME_CODE5    = 624;
    localparam int            TIME_CODE6    = 1248;
    localparam int            CNT_BITS      = 11;
    typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_CONV} adcsq_state_t;
endpackage : adcsq_pkg

// ### rtl/adcsq_timer.sv
// conversion-time counter: maps the time code to oscillator periods and counts them
`timescale 1ns/1ns
module adcsq_timer
    import adcsq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [2:0] time_code,
    output logic            done
);
    logic [CNT_BITS-1:0] count;
    logic                running;
    logic [CNT_BITS-1:0] load_value;

    function automatic logic [CNT_BITS-1:0] periods(input logic [2:0] code);
        case (code)
            3'h0:    periods = CNT_BITS'(TIME_CODE0);
            3'h2:    periods = CNT_BITS'(TIME_CODE2);
            3'h3:    periods = CNT_BITS'(TIME_CODE3);
            3'h4:    periods = CNT_BITS'(TIME_CODE4);
            3'h5:    periods = CNT_BITS'(TIME_CODE5);
            3'h6:    periods = CNT_BITS'(TIME_CODE6);
            // reserved codes fall back to the longest time, the safe choice
            default: periods = CNT_BITS'(TIME_CODE6);
        endcase
    endfunction : periods

    assign load_value = periods(time_code) - CNT_BITS'(1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                count   <= load_value;
                running <= 1'b1;
            end else if (running) begin
                if (count == '0) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count - CNT_BITS'(1);
                end
            end
        end
    end
endmodule : adcsq_timer

// ### rtl/adcsq_ctrl.sv
// converter sequencer control: AXI4-Lite registers, conversion sequencing, stop handling
// Summary of operation
// - start written as one in software mode begins a conversion at once when idle, else when the running one ends
// - after the conversion time, store result, set end flag, raise done interrupt
// - reading the result high register clears the end flag
// - a new start clears end flag but keeps old result until completion
// - stop entry aborts conversion and resets both control registers
// - stop entry discards stored results
// - after stop, no conversion resumes without a new software start
// - ladder is disconnected from reference while stopped
// - each conversion gives a 10-bit unsigned code
// - repeat mode relaunches after each completion; mode 00 aborts without storing
// - start bit clears itself once conversion begins
// - busy set on start, cleared on finish outside repeat mode and on stop entry
// - time code selects 39 to 1248 oscillator periods; 001 and 111 reserved
`timescale 1ns/1ns
module adcsq_ctrl
    import adcsq_pkg::*;
(
    input  wire logic                CLK_SYS,
    input  wire logic                RESET_N,
    input  wire logic [5:0]          S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [5:0]          S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    input  wire logic                STOP_ENTER,
    input  wire logic [RES_BITS-1:0] CONV_CODE,
    output logic [3:0]               CHANNEL_SELECT,
    output logic                     ANALOG_INPUT_DISABLE,
    output logic                     SAMPLE_ENABLE,
    output logic                     LADDER_CONNECT,
    output logic                     CONVERSION_DONE_IRQ,
    output logic                     IRQ
);
    ////////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]          ctrl_one;
    logic [7:0]          ctrl_two;
    logic [RES_BITS-1:0] result;
    logic                eoc_flag;
    logic                busy;
    logic                irq_stat;
    logic                irq_mask;
    logic                stop_mode;
    logic                stop_prev;
    adcsq_state_t        state;
    adcsq_state_t        next_state;
    logic                timer_done;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: write takes address and data in either order, one at a time
    logic       aw_held;
    logic       w_held;
    logic [5:0] aw_addr;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       ar_taken;
    logic       wr_fire;
    logic       wr_ok;
    logic       rd_ok;
    logic [5:0] rd_addr;

    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign wr_fire       = aw_held && w_held && !S_AXI_BVALID;
    assign ar_taken      = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_addr       = S_AXI_ARADDR;

    function automatic logic mapped(input logic [5:0] a);
        mapped = (a == OFF_CTRL_ONE) || (a == OFF_CTRL_TWO) || (a == OFF_RES_HIGH) || (a == OFF_RES_LOW)
              || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) || (a == OFF_STOP_CTRL);
    endfunction : mapped

    assign wr_ok = mapped(aw_addr);
    assign rd_ok = mapped(rd_addr);

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_byte  <= '0;
            w_lane0 <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= 2'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held  <= 1'b1;
                w_byte  <= S_AXI_WDATA[7:0];
                w_lane0 <= S_AXI_WSTRB[0];
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? 2'h0 : 2'h2;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // read data is captured at the address edge; a result-high read clears the end flag there too
    logic [7:0] rd_mux;
    logic       rd_result;
    assign rd_result = ar_taken && (rd_addr == OFF_RES_HIGH);
    always_comb begin
        case (rd_addr)
            OFF_CTRL_ONE:  rd_mux = ctrl_one;
            OFF_CTRL_TWO:  rd_mux = {2'h0, ctrl_two[5:0]};
            OFF_RES_HIGH:  rd_mux = result[9:2];
            OFF_RES_LOW:   rd_mux = {result[1:0], eoc_flag, busy, 4'h0};
            OFF_IRQ_STAT:  rd_mux = {7'h0, irq_stat};
            OFF_IRQ_MASK:  rd_mux = {7'h0, irq_mask};
            OFF_STOP_CTRL: rd_mux = {7'h0, stop_mode};
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= 2'h0;
        end else if (ar_taken) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h0, rd_mux};
            S_AXI_RRESP  <= rd_ok ? 2'h0 : 2'h2;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode of register writes and sequencing conditions
    logic wr_one;
    logic wr_two;
    logic wr_stat;
    logic wr_mask;
    logic wr_stop;
    logic stop_entry;
    logic mode_off;
    logic start_req;
    logic launch;
    logic abort;
    logic finish;

    assign wr_one     = wr_fire && w_lane0 && (aw_addr == OFF_CTRL_ONE) && !stop_mode;
    assign wr_two     = wr_fire && w_lane0 && (aw_addr == OFF_CTRL_TWO) && !stop_mode;
    assign wr_stat    = wr_fire && w_lane0 && (aw_addr == OFF_IRQ_STAT);
    assign wr_mask    = wr_fire && w_lane0 && (aw_addr == OFF_IRQ_MASK);
    assign wr_stop    = wr_fire && w_lane0 && (aw_addr == OFF_STOP_CTRL);
    assign stop_entry = stop_mode && !stop_prev;
    assign mode_off   = ctrl_one[POS_MODE +: 2] == MODE_OFF;
    // start only acts when idle; a start written while converting stays set and launches once the state returns to idle
    assign start_req  = ctrl_one[POS_START] && !mode_off && !stop_mode;
    assign launch     = (state == ADCSQ_IDLE) && start_req;
    assign abort      = stop_entry || ((state == ADCSQ_CONV) && mode_off);
    // abort outranks completion, so a cut conversion never stores a code
    assign finish     = (state == ADCSQ_CONV) && timer_done && !abort;

    always_comb begin
        next_state = state;
        case (state)
            ADCSQ_IDLE: if (launch) next_state = ADCSQ_CONV;
            ADCSQ_CONV: begin
                if (abort) next_state = ADCSQ_IDLE;
                else if (finish && (ctrl_one[POS_MODE +: 2] != MODE_REPEAT)) next_state = ADCSQ_IDLE;
            end
            default: next_state = ADCSQ_IDLE;
        endcase
    end

    logic relaunch;
    assign relaunch = finish && (ctrl_one[POS_MODE +: 2] == MODE_REPEAT);

    // a relaunch reloads the counter in the finish cycle, so repeat mode loses no period
    adcsq_timer u_timer (
        .clk       (CLK_SYS),
        .rst_n     (rst_n),
        .start     (launch || relaunch),
        .abort     (abort),
        .time_code (ctrl_two[POS_TIME +: 3]),
        .done      (timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // stop mode and control registers
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            stop_mode <= 1'b0;
            stop_prev <= 1'b0;
        end else begin
            // sticky: the pin only sets it, software leaves stop by writing zero
            stop_mode <= STOP_ENTER || (wr_stop ? w_byte[0] : stop_mode);
            stop_prev <= stop_mode;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one <= RST_CTRL_ONE;
            ctrl_two <= RST_CTRL_TWO;
        end else if (stop_mode) begin
            ctrl_one <= RST_CTRL_ONE;
            ctrl_two <= RST_CTRL_TWO;
        end else begin
            if (wr_one) ctrl_one <= w_byte;
            // a start written in the launch cycle is dropped, unlike a start written later while busy, which stays pending
            if (launch) ctrl_one[POS_START] <= 1'b0;
            if (wr_two) ctrl_two <= (w_byte & 8'h2e) | CTRL_TWO_FIX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion state, result and flags
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ADCSQ_IDLE;
            busy     <= 1'b0;
            eoc_flag <= 1'b0;
            result   <= '0;
            CONVERSION_DONE_IRQ <= 1'b0;
        end else begin
            state <= next_state;
            // busy drops on the edge that stores the code except in repeat mode, where busy stays set alongside the end flag
            busy  <= (next_state == ADCSQ_CONV) && !stop_mode;
            CONVERSION_DONE_IRQ <= finish;
            if (stop_entry) begin
                result <= '0;
            end else if (finish) begin
                result <= CONV_CODE;
            end
            // set wins over the read clear
            if (finish) eoc_flag <= 1'b1;
            else if (launch || rd_result || stop_entry) eoc_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 1'b0;
            irq_mask <= 1'b0;
        end else begin
            if (finish) irq_stat <= 1'b1;
            else if (wr_stat && w_byte[0]) irq_stat <= 1'b0;
            if (wr_mask) irq_mask <= w_byte[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the analog core and the interrupt line
    assign CHANNEL_SELECT       = ctrl_one[POS_CHAN +: 4];
    assign ANALOG_INPUT_DISABLE = ctrl_one[POS_AIN_DIS];
    assign SAMPLE_ENABLE        = busy;
    assign LADDER_CONNECT       = !stop_mode && (ctrl_two[POS_LADDER] || busy);
    assign IRQ                  = irq_stat && irq_mask;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_start_busy: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        launch |=> busy && !ctrl_one[POS_START]
    ) else $error("start did not set busy");
    a_done_store: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        finish |=> eoc_flag && CONVERSION_DONE_IRQ && result == $past(CONV_CODE)
    ) else $error("completion lost");
    a_stat_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        finish |=> irq_stat
    ) else $error("completion did not set the interrupt status");
    a_irq_mask: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        !irq_mask |-> !IRQ
    ) else $error("masked interrupt reached the output");
    a_read_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        rd_result && !finish |=> !eoc_flag
    ) else $error("end flag not cleared");
    a_keep_result: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        launch && !stop_entry |=> !eoc_flag && $stable(result)
    ) else $error("result changed on restart");
    a_stop_init: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        stop_mode |=> ctrl_one == RST_CTRL_ONE && ctrl_two == RST_CTRL_TWO && !busy
    ) else $error("stop");
    a_stop_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        stop_entry |=> !busy && !eoc_flag && result == '0
    ) else $error("stop entry kept a result");
    a_exit_idle: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        stop_prev && !stop_mode |-> (state == ADCSQ_IDLE) && !ctrl_one[POS_START]
    ) else $error("conversion resumed after stop");
    a_ladder_off: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        stop_mode |-> !LADDER_CONNECT
    ) else $error("ladder connected in stop");
    a_mode_off: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (state == ADCSQ_CONV) && mode_off |=> !busy && !$rose(eoc_flag)
    ) else $error("mode off");
    a_abort_keep: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (state == ADCSQ_CONV) && mode_off && !stop_entry |=> $stable(result)
    ) else $error("aborted conversion stored a code");
    a_repeat_next: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        relaunch |=> busy && (state == ADCSQ_CONV)
    ) else $error("repeat mode did not relaunch");
    a_busy_finish: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        finish && !relaunch |=> !busy
    ) else $error("busy stayed set after completion");
    a_irq_pulse: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CONVERSION_DONE_IRQ |=> !CONVERSION_DONE_IRQ
    ) else $error("irq not a pulse");
    a_ladder_busy: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        !stop_mode && busy |-> LADDER_CONNECT
    ) else $error("ladder open during conversion");
endmodule : adcsq_ctrl

// ### testbench/adcsq_core_model.sv
// behavioural analog core: returns a code while sampling, noise otherwise
`timescale 1ns/1ns
module adcsq_core_model (
    input  wire logic       clk,
    input  wire logic       sample_en,
    input  wire logic [3:0] chan,
    input  wire logic [9:0] level,
    output logic      [9:0] code
);
    initial code = 10'h155;
    // outside a conversion the code toggles, so a late sample cannot match by luck
    always @(posedge clk) begin
        code <= sample_en ? level + {6'h0, chan} : ~code;
    end
endmodule : adcsq_core_model

// ### testbench/testbench.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ns
module testbench;
    import adcsq_pkg::*;
    logic        clk = 0, rst_n = 0, stop = 0;
    logic [5:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [9:0]  level = 0, cv;
    wire         awready, wready, bvalid, arready, rvalid, done, irq, smp, ladder, aind;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [3:0]  chan;
    wire  [9:0]  code;
    logic [1:0]  bq[$];
    logic [65:0] rq[$];
    logic [65:0] re;
    int          n_errors = 0, comparisons = 0, n, seed = 32'h7784e3da;
    int          tt[8] = '{TIME_CODE0, TIME_CODE6, TIME_CODE2, TIME_CODE3, TIME_CODE4, TIME_CODE5,
                           TIME_CODE6, TIME_CODE6};

    always #10 clk = ~clk;

    adcsq_ctrl dut (
        .CLK_SYS(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .STOP_ENTER(stop), .CONV_CODE(code), .CHANNEL_SELECT(chan), .ANALOG_INPUT_DISABLE(aind),
        .SAMPLE_ENABLE(smp), .LADDER_CONNECT(ladder), .CONVERSION_DONE_IRQ(done), .IRQ(irq)
    );

    adcsq_core_model core (.clk(clk), .sample_en(smp), .chan(chan), .level(level), .code(code));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int t;
        t = 0;
        bq.push_back(er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        do begin
            @(posedge clk);
            t++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!(bvalid && bready) && t < 50);
        if (!(bvalid && bready)) n_errors++;
        bready <= 0;
    endtask : wr

    // only the bits in m are compared: the low nibble of the result register is unspecified
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er = 2'h0);
        int t;
        t = 0;
        rq.push_back({er, m, e});
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1;
        rready  <= 1;
        do begin
            @(posedge clk);
            t++;
            if (arvalid && arready) arvalid <= 0;
        end while (!(rvalid && rready) && t < 50);
        if (!(rvalid && rready)) n_errors++;
        rready <= 0;
    endtask : rd

    task automatic wait_done(input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (done !== 1'b1 && k < lim);
    endtask : wait_done

    // second process: every bus answer is matched against the oldest note
    always @(posedge clk) begin
        if (bvalid && bready) check("bresp", bresp, bq.pop_front());
        if (rvalid && rready) begin
            re = rq.pop_front();
            check("rdata", rdata & re[63:32], re[31:0] & re[63:32]);
            check("rresp", rresp, re[65:64]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rd(OFF_CTRL_ONE, 32'h1f, 32'hff);
        rd(OFF_CTRL_TWO, 32'h10, 32'h3f);
        rd(OFF_IRQ_STAT, 32'h0, 32'h1);
        rd(6'h1c, 32'h0, 32'hffffffff, 2'h2);
        wr(6'h1c, 32'h0, 2'h2);
        wr(OFF_IRQ_MASK, 32'h1);
        for (int tc = 0; tc < 8; tc++) begin
            level <= 10'($random(seed));
            wr(OFF_CTRL_ONE, tc[0] ? 32'h44 : 32'h24);
            check("channel", chan, 32'h4);
            check("input enable", aind, 32'h0);
            wr(OFF_CTRL_TWO, 32'h10 | (tc << 1));
            check("ladder idle", ladder, 0);
            wr(OFF_CTRL_ONE, tc[0] ? 32'hc4 : 32'ha4);
            @(posedge clk);
            check("busy", smp, 1);
            check("ladder busy", ladder, 1);
            wait_done(1400, n);
            check("duration", n >= tt[tc] - 3 && n <= tt[tc] + 3, 1);
            @(posedge clk);
            check("pulse", done, 0);
            check("irq", irq, 1);
            check("idle", smp, 0);
            cv = level + 10'h4;
            rd(OFF_RES_LOW, {cv[1:0], 6'h20}, 32'hf0);
            rd(OFF_RES_HIGH, cv[9:2], 32'hff);
            rd(OFF_RES_LOW, 32'h0, 32'h20);
            wr(OFF_IRQ_STAT, 32'h1);
            @(posedge clk);
            check("irq clear", irq, 0);
        end
        // restart before reading: old result must survive, masked event stays quiet
        wr(OFF_CTRL_TWO, 32'h10);
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_CTRL_ONE, 32'ha4);
        wait_done(100, n);
        cv = level + 10'h4;
        level <= 10'($random(seed));
        wr(OFF_CTRL_ONE, 32'ha4);
        rd(OFF_RES_LOW, 32'h10, 32'h30);
        rd(OFF_CTRL_ONE, 32'h24, 32'hff);
        rd(OFF_RES_HIGH, cv[9:2], 32'hff);
        wait_done(100, n);
        check("irq masked", irq, 0);
        cv = level + 10'h4;
        rd(OFF_RES_HIGH, cv[9:2], 32'hff);
        wr(OFF_IRQ_MASK, 32'h1);
        @(posedge clk);
        check("irq unmasked", irq, 1);
        wr(OFF_IRQ_STAT, 32'h1);
        // repeat mode, then abort by mode off
        wr(OFF_CTRL_ONE, 32'he4);
        wait_done(100, n);
        wait_done(100, n);
        check("relaunch", n >= TIME_CODE0 - 3 && n <= TIME_CODE0 + 3, 1);
        cv = level + 10'h4;
        level <= 10'($random(seed));
        repeat (10) @(posedge clk);
        wr(OFF_CTRL_ONE, 32'h04);
        @(posedge clk);
        check("aborted", smp, 0);
        wait_done(100, n);
        check("no result", n, 100);
        rd(OFF_RES_HIGH, cv[9:2], 32'hff);
        // stop entry in mid conversion
        wr(OFF_CTRL_TWO, 32'h30);
        @(posedge clk);
        check("ladder always", ladder, 1);
        wr(OFF_CTRL_ONE, 32'ha4);
        repeat (5) @(posedge clk);
        stop <= 1;
        repeat (3) @(posedge clk);
        check("stop busy", smp, 0);
        check("stop ladder", ladder, 0);
        wr(OFF_CTRL_ONE, 32'ha4);
        rd(OFF_CTRL_ONE, 32'h1f, 32'hff);
        rd(OFF_CTRL_TWO, 32'h10, 32'h3f);
        check("stop channel", chan, 32'hf);
        check("stop input", aind, 32'h1);
        rd(OFF_RES_HIGH, 32'h0, 32'hff);
        rd(OFF_RES_LOW, 32'h0, 32'hf0);
        stop <= 0;
        wr(OFF_STOP_CTRL, 32'h0);
        wait_done(100, n);
        check("no resume", n, 100);
        check("stays idle", smp, 0);
        summarize();
    end

    initial begin
        #400000;
        n_errors++;
        summarize();
    end
endmodule : testbench
